// File: setpoint_logic_controller.v
// Purpose: sixteen-unit setpoint alarm and control logic, only setpoints 0 to 3 configurable, with relay and counter actions
// Assumes: measured values and binary inputs are synchronous to clk_sys
// Notes:   registers reached over classic Wishbone, one aligned word each
//
// Overview of operation
// R01: Sixteen independent setpoints, each with one selectable trigger argument; here only setpoints 0 to 3 are writable over Wishbone.
// R02: All setpoints evaluated once per mains cycle, 16.6 ms or 20 ms.
// R03: A true setpoint drives a relay or increments a counter.
// R04: Programmable operate delay, 0.1 to 999.9 s, before entering operated state.
// R05: Programmable release delay, 0.1 to 999.9 s, before leaving operated state.
// R06: Analog trigger operates at one threshold, releases at another, giving hysteresis.
// R07: Software sets release equal to operate limit for no hysteresis.
// R08: Binary triggers test on/off status only; thresholds ignored.
// R09: Binary triggers are level sensitive, not edge events.
// R10: Status changes only after the condition held the whole delay.
// R11: Each status change is written to a readable status register.
// R12: Operated status latches in an alarm latch until software clears it.
// R13: Action fires on transition into operated state, not release.
// R14: Actions are independent per setpoint; relays are ORed across linked setpoints.
// R15: Relay holds until all linked setpoints release; latched relays need release command.
// R16: Time-count action accumulates operated time in 0.1 hour steps.
// R17: Four general counters of six decimal digits each.
// R18: Delay timers tick at 0.1 s and restart when the condition drops.
// R19: Status and alarm latch update in the same scan as the change.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "setpoint_defines.vh"
module setpoint_logic_controller #(
  parameter NUM_SP     = 16,
  parameter NUM_IN     = 16,
  parameter NUM_RELAY  = 4,
  parameter NUM_CNT    = 4,
  parameter TICK_CYC   = `TICK_CYCLES,
  parameter SCAN60_CYC = `SCAN60_CYCLES,
  parameter SCAN50_CYC = `SCAN50_CYCLES,
  parameter HOUR_TICKS = `HOUR_TENTH_TICKS
) (
  // Clock, reset, enable
  input  wire                   clk_sys,
  input  wire                   rst_n,
  input  wire                   clkEn,
  // Wishbone slave
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [7:0]             wb_adr_i,
  input  wire [3:0]             wb_sel_i,
  input  wire [31:0]            wb_dat_i,
  output reg  [31:0]            wb_dat_o,
  output reg                    wb_ack_o,
  // Measurements: NUM_SP signed analog values, 32 bits each, one per trigger source
  input  wire [NUM_SP*32-1:0]   analogIn,
  input  wire [NUM_IN-1:0]      binaryIn,
  // Relay outputs
  output reg  [NUM_RELAY-1:0]   relayOut
);

  localparam CW = 20;
  localparam [7:0] SP_TOP = `REG_SP_BASE + 8'h3F;

  // Configuration storage
  reg [31:0]          opLim_r  [0:NUM_SP-1];
  reg [31:0]          relLim_r [0:NUM_SP-1];
  reg [27:0]          delays_r [0:NUM_SP-1];
  reg [15:0]          cfg_r    [0:NUM_SP-1];
  reg                 mode50_r;
  reg [NUM_SP-1:0]    statusReg_r;
  reg [NUM_SP-1:0]    latch_r;
  reg [NUM_RELAY-1:0] relayLatched_r;
  reg [NUM_RELAY-1:0] relayHeld_r;
  reg [CW-1:0]        count_r  [0:NUM_CNT-1];
  reg [11:0]          hourTicks_r [0:NUM_CNT-1];
  reg [27:0]          tickCnt_r;
  reg [23:0]          scanCnt_r;
  reg                 tick_r;
  reg                 scan_r;
  reg [NUM_SP-1:0]    prevOp_r;

  wire [NUM_SP-1:0]   operated;
  wire                wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire                wbWr   = wbReq & wb_we_i;

  integer i;
  integer k;

  // Byte-lane merge for writes
  function [31:0] merge;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0]  sel;
    begin
      merge = { sel[3] ? newV[31:24] : oldV[31:24], sel[2] ? newV[23:16] : oldV[23:16],
                sel[1] ? newV[15:8]  : oldV[15:8],  sel[0] ? newV[7:0]   : oldV[7:0] };
    end
  endfunction

  // Six-digit add that wraps from 999999 to zero
  function [CW-1:0] bump;
    input [CW-1:0] v;
    begin
      bump = (v >= `CNT_MAX) ? {CW{1'b0}} : v + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Trigger condition for entering or leaving the operated state
  function condOf;
    input [1:0]  kind;
    input        isOp;
    input [31:0] val;
    input [31:0] lim;
    input        bin;
    input        pol;
    begin
      case (kind)
        `TRIG_ANA_HI: condOf = isOp ? ($signed(val) >= $signed(lim))
                                    : ($signed(val) <  $signed(lim));
        `TRIG_ANA_LO: condOf = isOp ? ($signed(val) <= $signed(lim))
                                    : ($signed(val) >  $signed(lim));
        `TRIG_BIN:    condOf = isOp ? (bin == pol) : (bin != pol);
        default:      condOf = ~isOp;
      endcase
    end
  endfunction

  // Merged write words; sliced on purpose to the register widths
  wire [1:0]  spIdx    = wb_adr_i[5:4];
  wire [31:0] cfgWr    = merge({16'h0000, cfg_r[spIdx]}, wb_dat_i, wb_sel_i);
  wire [31:0] delWr    = merge({4'h0, delays_r[spIdx]}, wb_dat_i, wb_sel_i);
  wire [31:0] latchClr = merge(32'h0000_0000, wb_dat_i, wb_sel_i);

  // 0.1 s tick and mains-cycle scan strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= 28'h000_0000;
      scanCnt_r <= 24'h00_0000;
      tick_r    <= 1'b0;
      scan_r    <= 1'b0;
    end else if (clkEn) begin
      tick_r <= (tickCnt_r == TICK_CYC - 1);
      tickCnt_r <= (tickCnt_r == TICK_CYC - 1) ? 28'h000_0000 : tickCnt_r + 28'h000_0001;
      // One scan per mains cycle; 50 Hz uses the 20 ms period, 60 Hz the 16.6 ms one
      if (scanCnt_r >= (mode50_r ? SCAN50_CYC - 1 : SCAN60_CYC - 1)) begin
        scanCnt_r <= 24'h00_0000;                            // [R02]
        scan_r    <= 1'b1;
      end else begin
        scanCnt_r <= scanCnt_r + 24'h00_0001;
        scan_r    <= 1'b0;
      end
    end
  end

  // One delay unit per setpoint
  genvar g;
  generate
    for (g = 0; g < NUM_SP; g = g + 1) begin : spGen
      wire [3:0]  src  = cfg_r[g][5:2];
      wire [31:0] aval = analogIn[src*32 +: 32];
      wire        bval = binaryIn[src];
      // Binary kinds ignore limits; hysteresis from separate limits
      wire opC  = condOf(cfg_r[g][1:0], 1'b1, aval, opLim_r[g],  bval, cfg_r[g][6]); // [R06] [R08] [R09]
      wire relC = condOf(cfg_r[g][1:0], 1'b0, aval, relLim_r[g], bval, cfg_r[g][6]); // [R06]
      setpoint_delay_unit uDelay (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .clkEn      (clkEn),
        .tick       (tick_r),
        .scan       (scan_r),
        .opCond     (opC),
        .relCond    (relC),
        .opDelay    (delays_r[g][13:0]),
        .relDelay   (delays_r[g][27:14]),
        .operated_r (operated[g])                            // [R01]
      );
    end
  endgenerate

  // Status, latch, relay and counter actions
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      statusReg_r    <= {NUM_SP{1'b0}};
      latch_r        <= {NUM_SP{1'b0}};
      prevOp_r       <= {NUM_SP{1'b0}};
      relayHeld_r    <= {NUM_RELAY{1'b0}};
      relayOut       <= {NUM_RELAY{1'b0}};
      relayLatched_r <= {NUM_RELAY{1'b0}};
      mode50_r       <= 1'b0;
      for (k = 0; k < NUM_CNT; k = k + 1) begin
        count_r[k]     <= {CW{1'b0}};
        hourTicks_r[k] <= 12'h000;
      end
      for (k = 0; k < NUM_SP; k = k + 1) begin
        cfg_r[k]    <= 16'h0000;
        opLim_r[k]  <= 32'h0000_0000;
        relLim_r[k] <= 32'h0000_0000;
        delays_r[k] <= 28'h000_0000;
      end
    end else if (clkEn) begin
      prevOp_r    <= operated;
      statusReg_r <= operated;                               // [R11] [R19]
      // Software writes first so hardware sets below win over clears
      if (wbWr) begin
        if (wb_adr_i == `REG_CTRL && wb_sel_i[0])
          mode50_r <= wb_dat_i[0];
        if (wb_adr_i == `REG_RELAY_REL)
          relayLatched_r <= relayLatched_r & ~wb_dat_i[NUM_RELAY-1:0]; // [R15]
        for (k = 0; k < NUM_CNT; k = k + 1)
          if (wb_adr_i == `REG_CNT_BASE + k*4)
            count_r[k] <= wb_dat_i[CW-1:0];
        for (k = 0; k < NUM_SP; k = k + 1)
          if (wb_adr_i[7:6] == 2'b01 && wb_adr_i[5:2] == k) begin
            // Empty match on [5:2]; block index is wb_adr_i[5:4] and word select [3:2], below
          end
      end
      if (wbWr && wb_adr_i >= `REG_SP_BASE && wb_adr_i <= SP_TOP) begin
        // Block index in [5:4], word within the block in [3:2]
        case (wb_adr_i[3:2])
          `SP_CFG:    cfg_r[spIdx]    <= cfgWr[15:0];
          `SP_OPLIM:  opLim_r[spIdx]  <= merge(opLim_r[spIdx], wb_dat_i, wb_sel_i);
          `SP_RELLIM: relLim_r[spIdx] <= merge(relLim_r[spIdx], wb_dat_i, wb_sel_i);
          `SP_DELAYS: delays_r[spIdx] <= delWr[27:0];
          default:    ;
        endcase
      end
      // Alarm latch: set wins over same-cycle clear
      latch_r <= (wbWr && wb_adr_i == `REG_LATCH)
                 ? ((latch_r & ~latchClr[NUM_SP-1:0]) | operated)
                 : (latch_r | operated);                     // [R12] [R19]
      // Relay: OR of linked setpoints plus latched hold
      for (k = 0; k < NUM_RELAY; k = k + 1) begin
        relayHeld_r[k] <= 1'b0;
        for (i = 0; i < NUM_SP; i = i + 1)
          if (cfg_r[i][8:7] == `ACT_RELAY && cfg_r[i][10:9] == k && operated[i])
            relayHeld_r[k] <= 1'b1;                          // [R14] [R15]
      end
      for (i = 0; i < NUM_SP; i = i + 1)
        if (cfg_r[i][8:7] == `ACT_RELAY && cfg_r[i][11] && operated[i] && !prevOp_r[i])
          relayLatched_r[cfg_r[i][10:9]] <= 1'b1;           // [R15]
      relayOut <= relayHeld_r | relayLatched_r;              // [R03]
      // Event counting on assertion edge; time counting while operated
      for (k = 0; k < NUM_CNT; k = k + 1) begin
        for (i = 0; i < NUM_SP; i = i + 1) begin
          if (cfg_r[i][8:7] == `ACT_COUNT && cfg_r[i][10:9] == k
              && operated[i] && !prevOp_r[i])
            count_r[k] <= bump(count_r[k]);                  // [R03] [R13] [R14] [R17]
        end
        if (tick_r) begin
          for (i = 0; i < NUM_SP; i = i + 1)
            if (cfg_r[i][8:7] == `ACT_TIME && cfg_r[i][10:9] == k && operated[i]) begin
              if (hourTicks_r[k] >= HOUR_TICKS - 1) begin
                hourTicks_r[k] <= 12'h000;
                count_r[k]     <= bump(count_r[k]);          // [R16]
              end else begin
                hourTicks_r[k] <= hourTicks_r[k] + 12'h001;
              end
            end
        end
      end
    end
  end

  // Wishbone answer, one cycle after the request
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn) begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0000_0000;
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL:      wb_dat_o <= {31'h0, mode50_r};
          `REG_STATUS:    wb_dat_o <= {{(32-NUM_SP){1'b0}}, statusReg_r};
          `REG_LATCH:     wb_dat_o <= {{(32-NUM_SP){1'b0}}, latch_r};
          `REG_RELAY:     wb_dat_o <= {{(32-NUM_RELAY){1'b0}}, relayOut};
          default: begin
            for (k = 0; k < NUM_CNT; k = k + 1)
              if (wb_adr_i == `REG_CNT_BASE + k*4)
                wb_dat_o <= {{(32-CW){1'b0}}, count_r[k]};
          end
        endcase
      end
    end
  end

endmodule // setpoint_logic_controller

// File: setpoint_defines.vh
// Purpose: constants for the setpoint logic controller
// Assumes: 250 MHz system clock, classic Wishbone slave with 32-bit data
// Notes:   register offsets are byte addresses
`ifndef SETPOINT_DEFINES_VH
`define SETPOINT_DEFINES_VH

// Clock and timing
`define CLK_HZ            250000000
`define TICK_MS           100
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`define SCAN60_US         16600
`define SCAN50_US         20000
`define SCAN60_CYCLES     ((`CLK_HZ / 1000000) * `SCAN60_US)
`define SCAN50_CYCLES     ((`CLK_HZ / 1000000) * `SCAN50_US)
`define HOUR_TENTH_TICKS  3600

// Register map (byte offsets)
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_LATCH         8'h08
`define REG_RELAY         8'h0C
`define REG_RELAY_REL     8'h10
`define REG_CNT_BASE      8'h20
`define REG_SP_BASE       8'h40
`define SP_STRIDE         8'h10

// Per-setpoint word offsets within a setpoint block
`define SP_CFG            2'd0
`define SP_OPLIM          2'd1
`define SP_RELLIM         2'd2
`define SP_DELAYS         2'd3

// Trigger kinds
`define TRIG_OFF          2'd0
`define TRIG_ANA_HI       2'd1
`define TRIG_ANA_LO       2'd2
`define TRIG_BIN          2'd3

// Action kinds
`define ACT_NONE          2'd0
`define ACT_RELAY         2'd1
`define ACT_COUNT         2'd2
`define ACT_TIME          2'd3

// Counter limit for six decimal digits
`define CNT_MAX           20'd999999

`endif

// File: setpoint_delay_unit.v
// Purpose: operate/release delay evaluation for one setpoint
// Assumes: clocked every cycle, status changes only on scan, delay counts in 0.1 s ticks
// Notes:   a shared tick pulse advances the elapsed counters
`timescale 1ns/1ns
module setpoint_delay_unit (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        clkEn,
  // Timing
  input  wire        tick,
  input  wire        scan,
  // Condition and configuration
  input  wire        opCond,
  input  wire        relCond,
  input  wire [13:0] opDelay,
  input  wire [13:0] relDelay,
  // Result
  output reg         operated_r
);

  reg [13:0] elapsed_r;

  // Elapsed time of the condition opposing the current status; restarts on drop
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_r  <= 14'h0000;
      operated_r <= 1'b0;
    end else if (clkEn) begin
      if (!operated_r) begin
        if (!opCond) begin
          elapsed_r <= 14'h0000;                             // [R18]
        end else if (scan && elapsed_r >= opDelay) begin
          operated_r <= 1'b1;                                // [R04] [R10]
          elapsed_r  <= 14'h0000;
        end else if (tick && elapsed_r != 14'h3FFF) begin
          elapsed_r <= elapsed_r + 14'h0001;
        end
      end else begin
        if (!relCond) begin
          elapsed_r <= 14'h0000;                             // [R18]
        end else if (scan && elapsed_r >= relDelay) begin
          operated_r <= 1'b0;                                // [R05] [R10]
          elapsed_r  <= 14'h0000;
        end else if (tick && elapsed_r != 14'h3FFF) begin
          elapsed_r <= elapsed_r + 14'h0001;
        end
      end
    end
  end

endmodule // setpoint_delay_unit

// File: slc_props.sv
// Purpose: port checks for the setpoint controller
// Assumes: one clock domain, rst_n asynchronous low
// Notes:   bound to the design at the foot
`timescale 1ns/1ns
module slc_props #(
  parameter NUM_RELAY = 4
) (
  // Clock and reset
  input wire                 clk_sys,
  input wire                 rst_n,
  input wire                 clkEn,
  // Register bus
  input wire                 wb_cyc_i,
  input wire                 wb_stb_i,
  input wire                 wb_we_i,
  input wire [7:0]           wb_adr_i,
  input wire [31:0]          wb_dat_o,
  input wire                 wb_ack_o,
  // Relays
  input wire [NUM_RELAY-1:0] relayOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_next_edge_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  freeze_holds_a: assert property (!clkEn |=> $stable(relayOut) && $stable(wb_ack_o))
    else $error("state moved while frozen");
  reset_quiet_a: assert property ($rose(rst_n) |-> relayOut == '0 && !wb_ack_o)
    else $error("outputs active after reset");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |->
    wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  relay_readback_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C |->
    wb_dat_o[NUM_RELAY-1:0] == $past(relayOut))
    else $error("relay readback differs");
  ctrl_width_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |->
    wb_dat_o[31:1] == 31'h0000_0000)
    else $error("control read has extra bits");
endmodule // slc_props

bind setpoint_logic_controller slc_props #(.NUM_RELAY(NUM_RELAY)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .relayOut(relayOut));

// File: slc_field_model.sv
// Purpose: measurement engine stand-in feeding levels
// Assumes: levels requested by the bench, one clock
// Notes:   unused analog channels drift so nothing stale sits there
`timescale 1ns/1ns
module slc_field_model (
  // Clock and requested levels
  input wire         clk_sys,
  input wire [31:0]  anaLevel,
  input wire [15:0]  binLevel,
  // Toward the controller
  output reg [511:0] analogIn,
  output reg [15:0]  binaryIn
);
  reg [31:0] drift = 32'h0000_0000;

  // Levels held while present, never pulsed
  always @(posedge clk_sys) begin
    drift <= drift + 32'h0000_0001;
    analogIn <= {{15{drift}}, anaLevel};
    binaryIn <= binLevel;
  end

  initial begin
    analogIn = 512'h0;
    binaryIn = 16'h0000;
  end
endmodule // slc_field_model

// File: setpoint_logic_controller_bench.sv
// Purpose: register-level tests of the setpoint controller
// Assumes: short tick 10, scan 20, tenth-hour 3 ticks
// Notes:   waits on status by bounded polling
`timescale 1ns/1ns
module setpoint_logic_controller_bench;
  reg          clk_sys = 1'b0;
  reg          rst_n = 1'b0;
  reg          clkEn = 1'b1;
  reg          cyc = 1'b0;
  reg          stb = 1'b0;
  reg          we = 1'b0;
  reg  [7:0]   adr = 8'h00;
  reg  [31:0]  wdat = 32'h0000_0000;
  reg  [31:0]  anaLevel = 32'h0000_0000;
  reg  [15:0]  binLevel = 16'h0000;
  reg  [31:0]  rd;
  wire [31:0]  wb_dat_o;
  wire         wb_ack_o;
  wire [3:0]   relayOut;
  wire [511:0] analogIn;
  wire [15:0]  binaryIn;
  integer      err_total = 0;
  integer      total_checks = 0;
  integer      i;
  // Sp0 analog relay 0, sp1 count 1, sp2 binary relay 0, sp3 time 2
  reg  [31:0]  cfgTab [0:3] = '{32'h0000_0081, 32'h0000_0347, 32'h0000_00CB, 32'h0000_05CF};

  always #2 clk_sys = ~clk_sys;

  slc_field_model field (.clk_sys(clk_sys), .anaLevel(anaLevel), .binLevel(binLevel),
    .analogIn(analogIn), .binaryIn(binaryIn));

  setpoint_logic_controller #(.TICK_CYC(10), .SCAN60_CYC(20), .SCAN50_CYC(20),
    .HOUR_TICKS(3)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .analogIn(analogIn), .binaryIn(binaryIn), .relayOut(relayOut));

  // Verdict and end of run
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t bus timeout", $time);
        summarize;
      end
    end
  endtask

  task rdChk(input [7:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, e);
    end
  endtask

  // Poll one bit until it reaches v, bounded
  task pollBit(input [7:0] a, input integer b, input v);
    integer k;
    begin
      k = 0;
      xfer(1'b0, a, 32'h0000_0000);
      while (rd[b] !== v && k < 60) begin
        xfer(1'b0, a, 32'h0000_0000);
        k = k + 1;
      end
      chk({31'h0, rd[b]}, {31'h0, v});
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(8'h04, 32'h0000_0000);
    rdChk(8'h08, 32'h0000_0000);
    rdChk(8'h24, 32'h0000_0000);
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    rdChk(8'h14, 32'h0000_0000);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    rdChk(8'h00, 32'h0000_0001);
    // Binary setpoints get an unreachable limit: it must be ignored
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, {2'b01, i[1:0], 4'h0}, cfgTab[i]);
      xfer(1'b1, {2'b01, i[1:0], 4'h4}, i == 0 ? 32'h0000_0064 : 32'h7FFF_FFFF);
      xfer(1'b1, {2'b01, i[1:0], 4'h8}, i == 0 ? 32'h0000_0032 : 32'h7FFF_FFFF);
      xfer(1'b1, {2'b01, i[1:0], 4'hC}, i == 0 ? 32'h0000_4002 : 32'h0000_4001);
    end
    clkEn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    clkEn <= 1'b1;
    // Analog above operate limit; not yet operated early on
    anaLevel <= 32'h0000_0078;
    repeat (10) @(posedge clk_sys);
    rdChk(8'h04, 32'h0000_0000);
    pollBit(8'h04, 0, 1'b1);
    rdChk(8'h08, 32'h0000_0001);
    chk({28'h0, relayOut}, 32'h0000_0001);
    // Inside hysteresis band the setpoint stays operated
    anaLevel <= 32'h0000_0046;
    repeat (60) @(posedge clk_sys);
    rdChk(8'h04, 32'h0000_0001);
    anaLevel <= 32'h0000_0028;
    pollBit(8'h04, 0, 1'b0);
    chk({28'h0, relayOut}, 32'h0000_0000);
    rdChk(8'h08, 32'h0000_0001);
    xfer(1'b1, 8'h08, 32'h0000_0001);
    rdChk(8'h08, 32'h0000_0000);
    // Two setpoints share relay 0: released only when both are
    binLevel[2] <= 1'b1;
    anaLevel <= 32'h0000_0078;
    pollBit(8'h04, 0, 1'b1);
    pollBit(8'h04, 2, 1'b1);
    anaLevel <= 32'h0000_0028;
    pollBit(8'h04, 0, 1'b0);
    chk({28'h0, relayOut}, 32'h0000_0001);
    binLevel[2] <= 1'b0;
    pollBit(8'h0C, 0, 1'b0);
    // Short pulse is filtered, then two full operations count twice
    binLevel[1] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    binLevel[1] <= 1'b0;
    repeat (40) @(posedge clk_sys);
    rdChk(8'h24, 32'h0000_0000);
    for (i = 0; i < 2; i = i + 1) begin
      binLevel[1] <= 1'b1;
      repeat (80) @(posedge clk_sys);
      binLevel[1] <= 1'b0;
      repeat (80) @(posedge clk_sys);
    end
    rdChk(8'h24, 32'h0000_0002);
    // Time count over about 280 operated cycles at 30 per step
    binLevel[3] <= 1'b1;
    repeat (300) @(posedge clk_sys);
    binLevel[3] <= 1'b0;
    repeat (60) @(posedge clk_sys);
    xfer(1'b0, 8'h28, 32'h0000_0000);
    chk({31'h0, rd >= 32'h0000_0006 && rd <= 32'h0000_000A}, 32'h0000_0001);
    // Equal limits leave no band: operate at the limit, release just below
    xfer(1'b1, 8'h48, 32'h0000_0064);
    anaLevel <= 32'h0000_0064;
    pollBit(8'h04, 0, 1'b1);
    anaLevel <= 32'h0000_0063;
    pollBit(8'h04, 0, 1'b0);
    summarize;
  end
endmodule // setpoint_logic_controller_bench
